// *** verilog/ptsw_watchdog.sv ***
// Pretrigger edge capture, range-zero delay and missing-trigger watchdog
// Operation
// - One selectable edge, rising or falling, of the external pretrigger marks the pretrigger point.
// - Only the selected edge matters; the width of the input pulse has no effect.
// - A configured delay separates the pretrigger point from range zero.
// - All trigger outputs start in step with each accepted external pretrigger.
// - Timing uncertainty between the pretrigger and every trigger output stays below 0.014 us.
// - After more than 0.100 s without a pretrigger, substitute triggers are made at 250 Hz.
// - During substitute triggering, processing and outputs keep running and data is forced to zero.
// - A no-trigger flag is raised in status word one while the external trigger is missing.
// - A returning external edge ends substitute triggering at once without outside help.
// - Each trigger output has its own active-high or active-low sense.
module ptsw_watchdog #(
   parameter logic [ptsw_pkg::CNT_W-1:0] TIMEOUT_CYC =
      ptsw_pkg::CNT_W'(ptsw_pkg::TIMEOUT_CYC),
   parameter logic [ptsw_pkg::CNT_W-1:0] SUB_CYC     =
      ptsw_pkg::CNT_W'(ptsw_pkg::SUB_CYC)
) (
   input  wire logic                          mclk_i,
   input  wire logic                          nrst_i,
   input  wire logic                          ce_i,
   input  wire logic                          external_pretrigger_input_i,
   input  wire ptsw_pkg::ptsw_cfg_t           cfg_i,
   input  wire logic [ptsw_pkg::DATA_W-1:0]   data_i,
   output logic      [ptsw_pkg::DATA_W-1:0]   data_o,
   output logic      [ptsw_pkg::N_TRIG-1:0]   trig_o,
   output logic                               range_zero_o,
   output logic                               no_trigger_o,
   output logic      [15:0]                   status_word1_o
);
   // Fixed sync latency leaves only one clock period of uncertainty
   // jitter bound check
   localparam bit JITTER_OK = ptsw_pkg::CLK_PERIOD_NS < ptsw_pkg::JITTER_MAX_NS;
   localparam int NOTRIG_BIT = 0;

   ptsw_pkg::ptsw_state_t q, d;
   logic ext_edge;
   logic sub_fire;
   logic event_fire;

   // Output level for one trigger group from its pulse state and sense
   function automatic logic [ptsw_pkg::N_TRIG-1:0] trig_level(
      input logic                        active,
      input logic [ptsw_pkg::N_TRIG-1:0] sense);
      return active ? sense : ~sense;
   endfunction : trig_level

   always_comb begin
      ext_edge = cfg_i.fall_edge ? (!q.sync[1] && q.sync[2])
                                 : (q.sync[1] && !q.sync[2]);
   end

   always_comb begin
      d = q;
      sub_fire = 1'b0;
      d.sync = {q.sync[1:0], external_pretrigger_input_i};
      if (ext_edge) begin
         d.wd_cnt  = ptsw_pkg::CNT_RST;
         d.sub_cnt = ptsw_pkg::CNT_RST;
         d.subst   = 1'b0;
      end else if (!q.subst) begin
         if (q.wd_cnt == TIMEOUT_CYC - 1'b1) begin
            d.subst   = 1'b1;
            d.sub_cnt = ptsw_pkg::CNT_RST;
            sub_fire  = 1'b1;
         end else begin
            d.wd_cnt = q.wd_cnt + 1'b1;
         end
      end else begin
         if (q.sub_cnt == SUB_CYC - 1'b1) begin
            d.sub_cnt = ptsw_pkg::CNT_RST;
            sub_fire  = 1'b1;
         end else begin
            d.sub_cnt = q.sub_cnt + 1'b1;
         end
      end
      event_fire = ext_edge || sub_fire;
      d.rz = 1'b0;
      if (event_fire) begin
         d.dly_cnt = cfg_i.range_delay;
         d.dly_run = 1'b1;
      end else if (q.dly_run) begin
         if (q.dly_cnt == ptsw_pkg::DLY_RST) begin
            d.dly_run = 1'b0;
            d.rz      = 1'b1;
         end else begin
            d.dly_cnt = q.dly_cnt - 1'b1;
         end
      end
      if (event_fire) begin
         d.pulse_cnt = ptsw_pkg::PULSE_W'(ptsw_pkg::PULSE_CYC);
      end else if (q.pulse_cnt != ptsw_pkg::PULSE_RST) begin
         d.pulse_cnt = q.pulse_cnt - 1'b1;
      end
      for (int i = 0; i < ptsw_pkg::N_TRIG; i++) begin
         d.trig[i] = (d.pulse_cnt != ptsw_pkg::PULSE_RST) ? cfg_i.sense[i]
                                                            : !cfg_i.sense[i];
      end
      d.data = d.subst ? ptsw_pkg::DATA_RST : data_i;
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q.sync      <= ptsw_pkg::SYNC_RST;
         q.wd_cnt    <= ptsw_pkg::CNT_RST;
         q.sub_cnt   <= ptsw_pkg::CNT_RST;
         q.subst     <= 1'b0;
         q.dly_cnt   <= ptsw_pkg::DLY_RST;
         q.dly_run   <= 1'b0;
         q.rz        <= 1'b0;
         q.pulse_cnt <= ptsw_pkg::PULSE_RST;
         q.trig      <= '0;
         q.data      <= ptsw_pkg::DATA_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign data_o       = q.data;
   assign trig_o       = q.trig;
   assign range_zero_o = q.rz;
   assign no_trigger_o = q.subst;
   always_comb begin
      status_word1_o             = 16'h0000;
      status_word1_o[NOTRIG_BIT] = q.subst;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   chk_edge_restart: assert property ((ce_i && ext_edge) |=> q.wd_cnt == '0)
      else $error("timeout not restarted by edge");
   chk_edge_pulse: assert property ((ce_i && ext_edge)
                                    |=> q.pulse_cnt == ptsw_pkg::PULSE_W'(ptsw_pkg::PULSE_CYC))
      else $error("edge did not start trigger pulse");
   chk_level_ignored: assert property ((q.sync[1] == q.sync[2]) |-> !ext_edge)
      else $error("edge seen on steady level");
   chk_trig_sync: assert property ((ce_i && ext_edge) |=> trig_o == cfg_i.sense)
      else $error("triggers not active after edge");
   chk_jitter_bound: assert property (JITTER_OK)
      else $error("clock period exceeds jitter bound");
   chk_rz_cause: assert property ((range_zero_o && $past(ce_i))
                                  |-> $past(q.dly_run) && $past(q.dly_cnt) == '0)
      else $error("range zero without expired delay");
   chk_wd_bound: assert property (q.wd_cnt <= TIMEOUT_CYC - 1'b1)
      else $error("timeout count overran");
   chk_sub_enter: assert property ((ce_i && !q.subst && !ext_edge
                                    && q.wd_cnt == TIMEOUT_CYC - 1'b1)
                                   |=> no_trigger_o
                                       && q.pulse_cnt == ptsw_pkg::PULSE_W'(ptsw_pkg::PULSE_CYC))
      else $error("substitute mode not entered at timeout");
   chk_sub_period: assert property ((ce_i && q.subst && !ext_edge
                                     && q.sub_cnt == SUB_CYC - 1'b1)
                                    |=> q.sub_cnt == '0
                                        && q.pulse_cnt == ptsw_pkg::PULSE_W'(ptsw_pkg::PULSE_CYC))
      else $error("substitute trigger missing");
   chk_data_zero: assert property (q.subst |-> data_o == '0)
      else $error("data not zeroed during substitution");
   chk_flag_word: assert property (status_word1_o[NOTRIG_BIT] == no_trigger_o)
      else $error("status word flag mismatch");
   chk_resume: assert property ((ce_i && ext_edge) |=> !no_trigger_o)
      else $error("no resume on returning edge");
   chk_idle_sense: assert property ((q.pulse_cnt == '0 && $stable(cfg_i.sense) && $past(ce_i)
                                     && $past(nrst_i))
                                    |-> trig_o == trig_level(1'b0, cfg_i.sense))
      else $error("idle trigger level wrong");
   chk_trig_active: assert property ((q.pulse_cnt != '0 && $stable(cfg_i.sense) && $past(ce_i)
                                      && $past(nrst_i))
                                     |-> trig_o == trig_level(1'b1, cfg_i.sense))
      else $error("active trigger level wrong");

   // Range zero delay path
   chk_rz_fire: assert property ((ce_i && q.dly_run && q.dly_cnt == '0 && !event_fire)
                                 |=> range_zero_o)
      else $error("range zero missing at delay end");
   chk_rz_load: assert property ((ce_i && event_fire)
                                 |=> q.dly_run && q.dly_cnt == $past(cfg_i.range_delay))
      else $error("range delay not loaded");
   chk_rz_single: assert property ((ce_i && range_zero_o)
                                   |=> !range_zero_o)
      else $error("range zero longer than one cycle");
   chk_pulse_count: assert property ((ce_i && !event_fire && q.pulse_cnt != '0)
                                     |=> q.pulse_cnt == $past(q.pulse_cnt) - 1'b1)
      else $error("trigger pulse count skipped");

   // Edge selection and fixed latency
   chk_rise_only: assert property ((!cfg_i.fall_edge && q.sync[2] && !q.sync[1])
                                   |-> !ext_edge)
      else $error("falling edge taken in rising mode");
   chk_fall_only: assert property ((cfg_i.fall_edge && !q.sync[2] && q.sync[1])
                                   |-> !ext_edge)
      else $error("rising edge taken in falling mode");
   chk_sync_shift: assert property (ce_i
                                    |=> q.sync[2:1] == $past(q.sync[1:0]))
      else $error("sync stage latency broken");
   chk_ce_freeze: assert property (!ce_i
                                   |=> $stable(q))
      else $error("state moved while disabled");

   // Watchdog and substitution
   chk_wd_count: assert property ((ce_i && !q.subst && !ext_edge
                                   && q.wd_cnt != TIMEOUT_CYC - 1'b1)
                                  |=> q.wd_cnt == $past(q.wd_cnt) + 1'b1)
      else $error("timeout count did not advance");
   chk_no_early: assert property ((ce_i && !q.subst && !ext_edge
                                   && q.wd_cnt != TIMEOUT_CYC - 1'b1)
                                  |=> !no_trigger_o)
      else $error("substitution entered early");
   chk_sub_hold: assert property ((ce_i && q.subst && !ext_edge)
                                  |=> no_trigger_o)
      else $error("substitution dropped without edge");
   chk_sub_bound: assert property (q.sub_cnt <= SUB_CYC - 1'b1)
      else $error("substitute count overran");
   chk_data_pass: assert property ((ce_i && !d.subst)
                                   |=> data_o == $past(data_i))
      else $error("data not passed in normal mode");
   chk_flag_rest: assert property (status_word1_o[15:1] == '0)
      else $error("status word spare bits set");

   cov_ext_edge: cover property (ce_i && ext_edge);
   cov_sub_entry: cover property (!no_trigger_o ##1 no_trigger_o);
   cov_resume: cover property (no_trigger_o ##1 !no_trigger_o);
   cov_range_zero: cover property (range_zero_o);
   cov_retrigger: cover property (ce_i && event_fire && q.pulse_cnt != '0);
endmodule : ptsw_watchdog

// *** verilog/ptsw_pkg.sv ***
// Package of constants and state types for the pretrigger watchdog
package ptsw_pkg;
   // Clock rate and documented times
   localparam int CLK_MHZ       = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int JITTER_MAX_NS = 14;
   localparam int TIMEOUT_US    = 100000;
   localparam int SUB_PERIOD_US = 4000;
   localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
   localparam int SUB_CYC       = SUB_PERIOD_US * CLK_MHZ;
   // Structure widths
   localparam int N_TRIG        = 4;
   localparam int CNT_W         = 24;
   localparam int DLY_W         = 16;
   localparam int DATA_W        = 16;
   localparam int PULSE_W       = 8;
   localparam int PULSE_CYC     = 10;
   // Reset values
   localparam logic [2:0]        SYNC_RST  = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_RST   = 24'h00_0000;
   localparam logic [DLY_W-1:0]  DLY_RST   = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
   localparam logic [PULSE_W-1:0] PULSE_RST = 8'h00;

   typedef struct packed {
      logic [N_TRIG-1:0] sense;
      logic              fall_edge;
      logic [DLY_W-1:0]  range_delay;
   } ptsw_cfg_t;

   typedef struct packed {
      logic [2:0]         sync;
      logic [CNT_W-1:0]   wd_cnt;
      logic [CNT_W-1:0]   sub_cnt;
      logic               subst;
      logic [DLY_W-1:0]   dly_cnt;
      logic               dly_run;
      logic               rz;
      logic [PULSE_W-1:0] pulse_cnt;
      logic [N_TRIG-1:0]  trig;
      logic [DATA_W-1:0]  data;
   } ptsw_state_t;
endpackage : ptsw_pkg

// *** testbench/ptsw_trig_src.sv ***
// Behavioural external trigger source driving the pretrigger pin
module ptsw_trig_src (
   input  wire logic mclk_i,
   output logic      pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial pin_o = 1'b0;
   task automatic pulse(input int lead, input int width);
      repeat (lead) @(posedge mclk_i);
      #2 pin_o = ~pin_o;
      repeat (width) @(posedge mclk_i);
      #2 pin_o = ~pin_o;
   endtask : pulse
endmodule : ptsw_trig_src

// *** testbench/tb_pretrigger_sync_watchdog.sv ***
// Self-checking bench for the pretrigger watchdog against a cycle model
module tb_pretrigger_sync_watchdog;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TO = 50;
   localparam int SC = 20;
   typedef struct {int s0, s1, s2, wd, sb, sub, d, p, rz, dat, tg;} ptsw_mdl_t;
   logic                mclk_i = 1'b0;
   logic                nrst_i = 1'b0;
   logic                ce_i   = 1'b1;
   logic                pin;
   ptsw_pkg::ptsw_cfg_t cfg    = '0;
   logic [15:0]         din    = 16'h0000;
   logic [15:0]         dout;
   logic [15:0]         st;
   logic [3:0]          trig;
   logic                rz;
   logic                nt;
   logic [31:0]         seed   = 32'h0000_C1B8;
   int                  miscompares = 0;
   int                  n_compared  = 0;
   int                  cyc         = 0;
   ptsw_mdl_t           m;
   always #5 mclk_i = ~mclk_i;
   ptsw_trig_src src (.mclk_i(mclk_i), .pin_o(pin));
   ptsw_watchdog #(.TIMEOUT_CYC(24'(TO)), .SUB_CYC(24'(SC))) uut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .external_pretrigger_input_i(pin),
      .cfg_i(cfg), .data_i(din), .data_o(dout), .trig_o(trig), .range_zero_o(rz),
      .no_trigger_o(nt), .status_word1_o(st));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [15:0] got, input int exp);
      n_compared++;
      if (got !== 16'(exp)) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, 16'(exp));
      end
   endtask : chk
   task automatic give_verdict();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   always @(posedge mclk_i or negedge nrst_i) begin : model
      int det;
      int fire;
      if (!nrst_i) begin
         m = '{default: 0};
      end else if (ce_i) begin
         det = cfg.fall_edge ? int'(m.s2 && !m.s1) : int'(m.s1 && !m.s2);
         fire = det || (!m.sb && m.wd == TO - 1) || (m.sb && m.sub == SC - 1);
         m.sub = (m.sb && m.sub != SC - 1) ? m.sub + 1 : 0;
         m.sb = int'(!det && (m.sb || m.wd == TO - 1));
         m.wd = det ? 0 : m.wd + 1;
         m.dat = m.sb ? 0 : int'(din);
         m.rz = int'(!fire && m.d == 1);
         m.d = fire ? int'(cfg.range_delay) + 1 : (m.d > 0 ? m.d - 1 : 0);
         m.p = fire ? ptsw_pkg::PULSE_CYC : (m.p > 0 ? m.p - 1 : 0);
         m.tg = {28'h000_0000, m.p != 0 ? cfg.sense : ~cfg.sense};
         m.s2 = m.s1;
         m.s1 = m.s0;
         m.s0 = int'(pin);
      end
   end
   always @(posedge mclk_i) begin
      #2;
      din <= 16'(rnd());
      ce_i <= (rnd() % 8) != 0;
   end
   always @(posedge mclk_i) begin
      #1;
      cyc++;
      chk(16'(trig), m.tg);
      chk(16'(rz), m.rz);
      chk(16'(nt), m.sb);
      chk(dout, m.dat);
      chk(st, m.sb);
      if (cyc == 10000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      #2 nrst_i = 1'b1;
      for (int t = 0; t < 8; t++) begin
         cfg = {4'(rnd()), t[0], 16'(rnd() % 16)};
         if (t == 4) begin
            nrst_i = 1'b0;
            #10 nrst_i = 1'b1;
         end
         repeat (4) src.pulse(6 + rnd() % 20, 6 + rnd() % 20);
         src.pulse(2, 6);
         repeat (TO + 3 * SC + rnd() % SC) @(posedge mclk_i);
         src.pulse(2, 6);
         $display("test %0d done", t);
      end
      repeat (20) @(posedge mclk_i);
      give_verdict();
   end
endmodule : tb_pretrigger_sync_watchdog
